//--- src/sms_pkg.sv
// ============================================================
// shared constants and types of the switch mode selector
package sms_pkg;
  // clock and slow tick
  localparam int CLK_HZ = 20000000; // system clock rate
  localparam int TICK_MS = 10; // slow tick period in ms
  localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS; // cycles per tick
  localparam int PULSE_MIN_MS = 250; // least supervisory pulse width in ms
  localparam int PULSE_TICKS = (PULSE_MIN_MS + TICK_MS - 1) / TICK_MS; // rounded up
  localparam logic [4:0] PULSE_TICKS_C = 5'(PULSE_TICKS);

  // event recorder type codes
  localparam logic [4:0] EVT_FAULT_TARGET = 5'h0e; // 14
  localparam logic [4:0] EVT_SWITCH_MODE = 5'h0f; // 15
  localparam logic [4:0] EVT_RECLOSER_MODE = 5'h10; // 16

  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_DELAY = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_CMD = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h14;
  localparam logic [7:0] OFS_IRQ_EN = 8'h18;

  // control register fields
  localparam int CTRL_MOMENTARY = 0;
  localparam int CTRL_SERIAL_SW = 1;
  localparam int CTRL_AUTO_RESET = 2;
  localparam int CTRL_SECONDARY = 3;
  localparam int CTRL_NON_RECLOSE = 4;
  localparam int CTRL_W = 5;
  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
  localparam logic [15:0] DELAY_RST = 16'h01f4; // 5 s in ticks
  localparam int CMD_TARGET_RESET = 0;

  // interrupt status fields
  localparam int IRQ_ENTER_SWITCH = 0;
  localparam int IRQ_ENTER_RECLOSER = 1;
  localparam int IRQ_FAULT_TARGET = 2;
  localparam int IRQ_W = 3;
  localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

  // status register fields
  localparam int ST_SWITCH = 0;
  localparam int ST_SUPER_REQ = 1;
  localparam int ST_TARGET = 2;
  localparam int ST_SEQ_LO = 4;
  localparam int ST_NR_OUT = 6;

  // event handed to the recorder
  typedef struct packed {
    logic valid; // one-cycle pulse
    logic [4:0] kind; // type code
  } sms_event_t;

  // fault sensing from the curve evaluation
  typedef struct packed {
    logic overcurrent; // pickup exceeded
    logic exceedPrimary; // primary_time_current_curve timed out
    logic exceedSecondary; // secondary_time_current_curve timed out
  } sms_fault_t;

  // resolved mode
  typedef enum logic [0:0] {
    MODE_RECLOSER = 1'b0,
    MODE_SWITCH = 1'b1
  } sms_mode_t;
endpackage : sms_pkg

//--- src/sms_switch_mode_selector.sv
// Behaviour
// - switch mode indicates overcurrent, never trips
// - level option: request follows supervisory voltage
// - momentary option: each valid pulse toggles request
// - pulses under quarter second are ignored
// - serial command also selects switch mode
// - status contact closed in switch mode
// - changeover contact closed in recloser mode
// - switch mode fault past curve logs 14
// - entering switch mode logs event 15
// - entering recloser mode logs event 16
// - target sensing, curve choice in both modes
// - auto target reset enable plus delay
// - serial or supervisory non-reclose clears targets
// - switch mode target holds sequence at one
// - target reset returns sequence to zero
// - non-reclose contact forced off in switch mode
// - recloser mode restores prior non-reclose state
// - mode is panel, serial or enabled supervisory request
//
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module sms_switch_mode_selector
  import sms_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC // shorten in simulation
)(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // front panel and supervisory inputs
  input wire logic panelSwitchMode,
  input wire logic panelSupervisoryOn,
  input wire logic supervisoryIn,
  input wire logic supervisoryNonReclose,
  // fault sensing
  input wire sms_fault_t fault,
  // outputs to the field
  output logic tripOut,
  output logic overcurrentInd,
  output logic switchContact,
  output logic changeoverContact,
  output logic nonRecloseContact,
  output logic targetInd,
  output logic [1:0] seqPos,
  output sms_event_t eventOut,
  output logic irq
);

  // ==========================================================
  // register bus decode
  wire logic setupPhase = psel & ~penable; // address valid, before access
  wire logic accessWr = psel & penable & pwrite; // write takes effect here
  wire logic hitCtrl = (paddr == OFS_CTRL);
  wire logic hitDelay = (paddr == OFS_DELAY);
  wire logic hitStatus = (paddr == OFS_STATUS);
  wire logic hitCmd = (paddr == OFS_CMD);
  wire logic hitIrqStat = (paddr == OFS_IRQ_STAT);
  wire logic hitIrqClr = (paddr == OFS_IRQ_CLR);
  wire logic hitIrqEn = (paddr == OFS_IRQ_EN);
  wire logic hitAny = hitCtrl | hitDelay | hitStatus | hitCmd | hitIrqStat | hitIrqClr | hitIrqEn;
  wire logic wrCtrl = accessWr & hitCtrl;
  wire logic wrDelay = accessWr & hitDelay;
  wire logic wrCmd = accessWr & hitCmd;
  wire logic wrIrqClr = accessWr & hitIrqClr;
  wire logic wrIrqEn = accessWr & hitIrqEn;

  // software registers
  logic [CTRL_W-1:0] ctrl_q; // mode options and serial requests
  logic [15:0] delay_q; // auto reset delay in ticks
  logic [IRQ_W-1:0] irqEn_q; // interrupt enables
  logic [IRQ_W-1:0] irqStat_q; // sticky event bits
  logic [IRQ_W-1:0] irqStat_d;
  logic [31:0] prdata_q; // read data captured in setup
  logic pslverr_q; // error flag captured in setup

  // ==========================================================
  // slow tick
  logic [17:0] tickCnt_q; // cycle counter inside a tick
  wire logic tick = (tickCnt_q == 18'(TICK_CYCLES - 1));

  // a free running tick keeps all slow timing on one shared divider
  always_ff @(posedge clk_sys)
  begin
    if (reset || tick)
      tickCnt_q <= 18'h00000;
    else
      tickCnt_q <= tickCnt_q + 18'h00001;
  end

  // ==========================================================
  // supervisory input qualification
  logic supMeta_q; // first synchroniser stage, read only by the second
  logic supSync_q; // second synchroniser stage
  logic [4:0] widthCnt_q; // ticks seen while the pulse is high
  logic pulseDone_q; // pulse already counted
  logic superReq_q; // toggled supervisory request

  // two flip-flop synchroniser
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      supMeta_q <= 1'b0;
      supSync_q <= 1'b0;
    end
    else
    begin
      supMeta_q <= supervisoryIn;
      supSync_q <= supMeta_q;
    end
  end

  // width reaches the minimum once per pulse; shorter ones never reach it
  wire logic widthMet = (widthCnt_q >= PULSE_TICKS_C);
  wire logic pulseQual = widthMet & ~pulseDone_q & supSync_q;

  // width counter, cleared whenever the input drops
  always_ff @(posedge clk_sys)
  begin
    if (reset || !supSync_q)
    begin
      widthCnt_q <= 5'h00;
      pulseDone_q <= 1'b0;
    end
    else
    begin
      if (tick && !widthMet)
        widthCnt_q <= widthCnt_q + 5'h01;
      if (pulseQual)
        pulseDone_q <= 1'b1;
    end
  end

  // momentary request toggles on each qualified pulse
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      superReq_q <= 1'b0;
    else if (pulseQual)
      superReq_q <= ~superReq_q;
  end

  // level option follows the input directly, momentary uses the toggle
  wire logic superMode = ctrl_q[CTRL_MOMENTARY] ? superReq_q : supSync_q;

  // ==========================================================
  // mode resolution
  wire logic superSwitch = panelSupervisoryOn & superMode;
  wire sms_mode_t modeNext = (panelSwitchMode | superSwitch | ctrl_q[CTRL_SERIAL_SW]) ?
                             MODE_SWITCH : MODE_RECLOSER;
  sms_mode_t mode_q; // resolved mode
  wire logic inSwitch = (mode_q == MODE_SWITCH);
  wire logic enterSwitch = (modeNext == MODE_SWITCH) & ~inSwitch;
  wire logic enterRecloser = (modeNext == MODE_RECLOSER) & inSwitch;

  // mode register; starts in recloser mode
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      mode_q <= MODE_RECLOSER;
    else
      mode_q <= modeNext;
  end

  // ==========================================================
  // fault sensing, targets and sequence position
  wire logic exceedSel = ctrl_q[CTRL_SECONDARY] ? fault.exceedSecondary : fault.exceedPrimary;
  logic exceedPrev_q; // edge detect on the selected curve
  wire logic exceedRise = exceedSel & ~exceedPrev_q;
  wire logic faultTarget = exceedRise & inSwitch;
  logic target_q; // target indicator latched
  logic [15:0] resetCnt_q; // ticks since target set
  wire logic autoReset = ctrl_q[CTRL_AUTO_RESET] & target_q & tick & (resetCnt_q >= delay_q);
  wire logic targetReset = autoReset | (wrCmd & pwdata[CMD_TARGET_RESET]) | supervisoryNonReclose;
  logic [1:0] seq_q; // operation sequence position

  // previous exceed level
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      exceedPrev_q <= 1'b0;
    else
      exceedPrev_q <= exceedSel;
  end

  // targets latch in either mode; a new fault wins over a reset
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      target_q <= 1'b0;
    else if (exceedRise)
      target_q <= 1'b1;
    else if (targetReset)
      target_q <= 1'b0;
  end

  // auto reset delay counts ticks from the last fault
  always_ff @(posedge clk_sys)
  begin
    if (reset || exceedRise || !target_q)
      resetCnt_q <= 16'h0000;
    else if (tick && resetCnt_q != 16'hffff)
      resetCnt_q <= resetCnt_q + 16'h0001;
  end

  // sequence stays at one during switch mode targets, zero on reset
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      seq_q <= 2'h0;
    else if (faultTarget)
      seq_q <= 2'h1;
    else if (targetReset && !exceedRise)
      seq_q <= 2'h0;
  end

  // ==========================================================
  // non-reclose state save and restore
  logic nrSaved_q; // state held before switch mode
  logic nrOut_q; // contact drive

  // capture on entry so software writes to the non-reclose bit during switch mode are undone
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      nrSaved_q <= 1'b0;
    else if (enterSwitch)
      nrSaved_q <= ctrl_q[CTRL_NON_RECLOSE];
  end

  // contact forced open in switch mode
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      nrOut_q <= 1'b0;
    else
      nrOut_q <= ctrl_q[CTRL_NON_RECLOSE] & (modeNext == MODE_RECLOSER);
  end

  // ==========================================================
  // event pulse to the recorder
  sms_event_t event_q;

  // mode changes outrank a fault in the same cycle; that fault still sets its irq bit
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      event_q <= '{valid: 1'b0, kind: 5'h00};
    else if (enterSwitch)
      event_q <= '{valid: 1'b1, kind: EVT_SWITCH_MODE};
    else if (enterRecloser)
      event_q <= '{valid: 1'b1, kind: EVT_RECLOSER_MODE};
    else if (faultTarget)
      event_q <= '{valid: 1'b1, kind: EVT_FAULT_TARGET};
    else
      event_q <= '{valid: 1'b0, kind: event_q.kind};
  end

  // ==========================================================
  // control registers
  wire logic [CTRL_W-1:0] ctrlWr = pwdata[CTRL_W-1:0];

  // control word; non-reclose bit restored on return to recloser mode
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      ctrl_q <= CTRL_RST;
    else if (enterRecloser)
      ctrl_q <= {nrSaved_q, (wrCtrl ? ctrlWr[CTRL_NON_RECLOSE-1:0] : ctrl_q[CTRL_NON_RECLOSE-1:0])};
    else if (wrCtrl)
      ctrl_q <= ctrlWr;
  end

  // delay and enables
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      delay_q <= DELAY_RST;
      irqEn_q <= IRQ_RST;
    end
    else
    begin
      if (wrDelay)
        delay_q <= pwdata[15:0];
      if (wrIrqEn)
        irqEn_q <= pwdata[IRQ_W-1:0];
    end
  end

  // sticky events: a set in the clearing cycle survives
  wire logic [IRQ_W-1:0] irqSet = {faultTarget, enterRecloser, enterSwitch};
  wire logic [IRQ_W-1:0] irqClr = wrIrqClr ? pwdata[IRQ_W-1:0] : IRQ_RST;
  assign irqStat_d = (irqStat_q & ~irqClr) | irqSet;

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      irqStat_q <= IRQ_RST;
    else
      irqStat_q <= irqStat_d;
  end

  // ==========================================================
  // read path, captured in setup so the access phase has no wait
  logic [31:0] statusWord;
  always_comb
  begin
    statusWord = 32'h00000000;
    statusWord[ST_SWITCH] = inSwitch;
    statusWord[ST_SUPER_REQ] = superMode;
    statusWord[ST_TARGET] = target_q;
    statusWord[ST_SEQ_LO +: 2] = seq_q;
    statusWord[ST_NR_OUT] = nrOut_q;
  end

  wire logic [31:0] readMux =
    hitCtrl ? {27'h0000000, ctrl_q} :
    hitDelay ? {16'h0000, delay_q} :
    hitStatus ? statusWord :
    hitIrqStat ? {29'h00000000, irqStat_q} :
    hitIrqEn ? {29'h00000000, irqEn_q} : 32'h00000000;

  // write-only and unmapped reads return zero
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      prdata_q <= 32'h00000000;
      pslverr_q <= 1'b0;
    end
    else if (setupPhase)
    begin
      prdata_q <= pwrite ? 32'h00000000 : readMux;
      pslverr_q <= ~hitAny;
    end
  end

  // ==========================================================
  // outputs
  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = pslverr_q & psel & penable;
  // trip only through the selected curve and only in recloser mode
  assign tripOut = exceedSel & ~inSwitch;
  assign overcurrentInd = fault.overcurrent;
  assign switchContact = inSwitch;
  assign changeoverContact = ~inSwitch;
  assign nonRecloseContact = nrOut_q;
  assign targetInd = target_q;
  assign seqPos = seq_q;
  assign eventOut = event_q;
  assign irq = |(irqStat_q & irqEn_q);

endmodule : sms_switch_mode_selector
`default_nettype wire

//--- tb/sms_sva_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// checker on the mode, contact and event pins
module sms_sva
  import sms_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // watched pins
  input wire logic panelSwitchMode,
  input wire sms_fault_t fault,
  input wire logic tripOut,
  input wire logic overcurrentInd,
  input wire logic switchContact,
  input wire logic changeoverContact,
  input wire logic nonRecloseContact,
  input wire logic targetInd,
  input wire logic [1:0] seqPos,
  input wire sms_event_t eventOut
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  // any cycle in switch mode must keep the trip output low
  AST_NO_TRIP: assert property (switchContact |-> !tripOut)
    else $error("trip while in switch mode");
  AST_OC_IND: assert property (overcurrentInd == fault.overcurrent)
    else $error("overcurrent indication lost");
  AST_CONTACTS: assert property (changeoverContact != switchContact)
    else $error("contacts not complementary");
  AST_NR_OFF: assert property (switchContact |-> !nonRecloseContact)
    else $error("non-reclose contact in switch mode");
  AST_EVT15: assert property ($rose(switchContact) |-> eventOut.valid && eventOut.kind == EVT_SWITCH_MODE)
    else $error("no switch mode event");
  AST_EVT16: assert property ($fell(switchContact) |-> eventOut.valid && eventOut.kind == EVT_RECLOSER_MODE)
    else $error("no recloser mode event");
  // panel is a plain level, a few edges is ample
  AST_PANEL: assert property (panelSwitchMode [*3] |-> switchContact)
    else $error("panel request ignored");
  AST_SEQ_SET: assert property ($rose(seqPos != 2'h0) |-> seqPos == 2'h1 && switchContact && targetInd)
    else $error("sequence moved off one");
  AST_EVT14: assert property ($rose(targetInd) && switchContact && $stable(switchContact)
    |-> eventOut.valid && eventOut.kind == EVT_FAULT_TARGET)
    else $error("no fault target event");
endmodule : sms_sva
bind sms_switch_mode_selector sms_sva u_sva (.clk_sys(clk_sys), .reset(reset), .panelSwitchMode(panelSwitchMode),
  .fault(fault), .tripOut(tripOut), .overcurrentInd(overcurrentInd), .switchContact(switchContact),
  .changeoverContact(changeoverContact), .nonRecloseContact(nonRecloseContact), .targetInd(targetInd),
  .seqPos(seqPos), .eventOut(eventOut));
`default_nettype wire

//--- tb/sms_scada_model.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// remote supervisory source: a level or a timed pulse
module sms_scada_model (
  // clock
  input wire logic clk_sys,
  // commands from the bench
  input wire logic levelOn,
  input wire logic [9:0] pulseLen,
  input wire logic pulseGo,
  // discrete line to the device
  output logic supervisoryIn
);
  logic [9:0] left_q = 10'h0; // cycles of pulse still to hold
  // pulse width is whatever the bench asks, short ones too
  always @(posedge clk_sys)
  begin
    if (pulseGo)
      left_q <= pulseLen;
    else if (left_q != 10'h0)
      left_q <= left_q - 10'h1;
  end
  assign supervisoryIn = levelOn | (left_q != 10'h0);
endmodule : sms_scada_model
`default_nettype wire

//--- tb/tb_switch_mode_selector.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// bench for the switch mode selector
module tb_switch_mode_selector
  import sms_pkg::*;
;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, irq, supervisoryIn, tripOut, overcurrentInd;
  logic panelSwitchMode = 1'b0, panelSupervisoryOn = 1'b0, supervisoryNonReclose = 1'b0;
  logic levelOn = 1'b0, pulseGo = 1'b0;
  logic [9:0] pulseLen = 10'h0;
  logic switchContact, changeoverContact, nonRecloseContact, targetInd;
  logic [1:0] seqPos;
  sms_fault_t fault = '0;
  sms_event_t eventOut;
  int fail_count = 0, total_checks = 0, cycles = 0;
  int evtCnt[32] = '{default: 0}; // events seen per type code
  always #25 clk_sys = ~clk_sys;
  sms_switch_mode_selector #(.TICK_CYCLES(10)) u_dut (.clk_sys(clk_sys), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .panelSwitchMode(panelSwitchMode), .panelSupervisoryOn(panelSupervisoryOn),
    .supervisoryIn(supervisoryIn), .supervisoryNonReclose(supervisoryNonReclose), .fault(fault),
    .tripOut(tripOut), .overcurrentInd(overcurrentInd), .switchContact(switchContact),
    .changeoverContact(changeoverContact), .nonRecloseContact(nonRecloseContact), .targetInd(targetInd),
    .seqPos(seqPos), .eventOut(eventOut), .irq(irq));
  sms_scada_model u_scada (.clk_sys(clk_sys), .levelOn(levelOn), .pulseLen(pulseLen), .pulseGo(pulseGo),
    .supervisoryIn(supervisoryIn));
  // count events and cut a hang short
  always @(posedge clk_sys)
  begin
    cycles++;
    if (eventOut.valid === 1'b1)
      evtCnt[eventOut.kind]++;
    if (cycles == 20000)
    begin
      fail_count++;
      stop_test();
    end
  end
  task cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cyc
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer; holds the request until pready is seen
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // no limit of its own; pready or the bench timeout ends this wait
    do
    begin
      @(posedge clk_sys);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask : apb
  task pulse(input logic [9:0] n);
    pulseLen <= n;
    pulseGo <= 1'b1;
    cyc(1);
    pulseGo <= 1'b0;
    cyc(400);
  endtask : pulse
  // panel selects switch mode; trip, contacts, events, irq
  task t_panel;
    int e15, e16;
    e15 = evtCnt[15];
    e16 = evtCnt[16];
    apb(1'b1, OFS_IRQ_EN, 32'h1);
    panelSwitchMode <= 1'b1;
    fault <= 3'b110;
    cyc(4);
    chk(switchContact, 1);
    chk(changeoverContact, 0);
    chk(tripOut, 0);
    chk(overcurrentInd, 1);
    chk(evtCnt[15] - e15, 1);
    chk(irq, 1);
    apb(1'b0, OFS_IRQ_STAT, 32'h0);
    chk(rd[0], 1);
    apb(1'b1, OFS_IRQ_CLR, 32'h7);
    chk(irq, 0);
    panelSwitchMode <= 1'b0;
    cyc(4);
    chk(changeoverContact, 1);
    chk(tripOut, 1);
    chk(evtCnt[16] - e16, 1);
    chk(irq, 0);
    fault <= '0;
    apb(1'b0, 8'h40, 32'h0);
    chk(err, 1);
    chk(rd, 0);
  endtask : t_panel
  // every panel, enable and level combination
  task t_table;
    for (int i = 0; i < 8; i++)
    begin
      panelSwitchMode <= i[2];
      panelSupervisoryOn <= i[1];
      levelOn <= i[0];
      cyc(6);
      chk(switchContact, i[2] | (i[1] & i[0]));
    end
    panelSwitchMode <= 1'b0;
    levelOn <= 1'b0;
  endtask : t_table
  // momentary: short pulse ignored, long ones toggle
  task t_moment;
    apb(1'b1, OFS_CTRL, 32'h1);
    pulse(10'd200);
    chk(switchContact, 0);
    pulse(10'd300);
    chk(switchContact, 1);
    pulse(10'd300);
    chk(switchContact, 0);
    panelSupervisoryOn <= 1'b0;
    apb(1'b1, OFS_CTRL, 32'h2);
    cyc(3);
    chk(switchContact, 1);
    apb(1'b1, OFS_CTRL, 32'h0);
    cyc(3);
    chk(switchContact, 0);
  endtask : t_moment
  // targets, sequence position, resets, curve choice
  task t_target;
    int e14;
    apb(1'b1, OFS_CMD, 32'h1);
    panelSwitchMode <= 1'b1;
    cyc(4);
    e14 = evtCnt[14];
    fault <= 3'b010;
    cyc(3);
    chk(targetInd, 1);
    chk(seqPos, 1);
    chk(evtCnt[14] - e14, 1);
    fault <= '0;
    cyc(2);
    fault <= 3'b010;
    cyc(3);
    chk(seqPos, 1);
    fault <= '0;
    apb(1'b1, OFS_CMD, 32'h1);
    cyc(2);
    chk(targetInd, 0);
    chk(seqPos, 0);
    fault <= 3'b010;
    cyc(2);
    fault <= '0;
    chk(targetInd, 1);
    supervisoryNonReclose <= 1'b1;
    cyc(3);
    chk(targetInd, 0);
    supervisoryNonReclose <= 1'b0;
    panelSwitchMode <= 1'b0;
    apb(1'b1, OFS_DELAY, 32'h3);
    apb(1'b1, OFS_CTRL, 32'hc);
    fault <= 3'b010;
    cyc(2);
    chk(tripOut, 0);
    fault <= 3'b001;
    cyc(2);
    chk(tripOut, 1);
    chk(targetInd, 1);
    fault <= '0;
    cyc(10);
    chk(targetInd, 1);
    cyc(60);
    chk(targetInd, 0);
  endtask : t_target
  // non-reclose forced off in switch mode, restored after
  task t_nr;
    apb(1'b1, OFS_CTRL, 32'h10);
    cyc(3);
    chk(nonRecloseContact, 1);
    panelSwitchMode <= 1'b1;
    cyc(4);
    chk(nonRecloseContact, 0);
    apb(1'b1, OFS_CTRL, 32'h0);
    panelSwitchMode <= 1'b0;
    cyc(4);
    chk(nonRecloseContact, 1);
  endtask : t_nr
  task stop_test;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  // reset, then the scenarios in turn
  initial
  begin
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    cyc(2);
    chk(changeoverContact, 1);
    apb(1'b0, OFS_DELAY, 32'h0);
    chk(rd, {16'h0, DELAY_RST});
    t_panel();
    t_table();
    t_moment();
    t_target();
    t_nr();
    stop_test();
  end
endmodule : tb_switch_mode_selector
`default_nettype wire
